// ==== common/asc_pkg.sv ====
// Purpose: Shared constants and types for the async static memory host controller.
// Assumes: 10 MHz system clock, 100 ns period.
// Notes:   Times are kept in ns; cycle counts are derived from them.
package asc_pkg;

  localparam int unsigned CLK_PERIOD_NS = 100;

  // Speed-grade timing figures in ns, slow grade used by default.
  localparam int unsigned READ_PERIOD_MIN_NS       = 55;
  localparam int unsigned WRITE_PERIOD_MIN_NS      = 55;
  localparam int unsigned ADDRESS_ACCESS_DELAY_NS  = 55;
  localparam int unsigned WRITE_PULSE_MIN_NS       = 40;
  localparam int unsigned WRITE_FLOAT_DELAY_NS     = 18;
  localparam int unsigned DATA_SETUP_TO_END_NS     = 28;
  localparam int unsigned OUTPUT_FLOAT_DELAY_NS    = 18;
  localparam int unsigned ADDRESS_SETUP_TO_START_NS = 0;

  // Least times round up, never below one cycle.
  function automatic int unsigned ns_to_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cyc

  localparam int unsigned READ_CYC  = ns_to_cyc(ADDRESS_ACCESS_DELAY_NS);
  localparam int unsigned WPULSE_CYC = ns_to_cyc(WRITE_PULSE_MIN_NS > WRITE_FLOAT_DELAY_NS
                                       + DATA_SETUP_TO_END_NS ? WRITE_PULSE_MIN_NS
                                       : WRITE_FLOAT_DELAY_NS + DATA_SETUP_TO_END_NS + 1);
  localparam int unsigned FLOAT_CYC  = ns_to_cyc(OUTPUT_FLOAT_DELAY_NS);
  localparam int unsigned RECOVER_CYC = ns_to_cyc(READ_PERIOD_MIN_NS);
  localparam int unsigned CNT_W = 4;

  localparam int unsigned ADDR_W = 20;
  localparam int unsigned DATA_W = 16;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_READ    = 3'b001,
    ST_WSETUP  = 3'b010,
    ST_WPULSE  = 3'b011,
    ST_WHOLD   = 3'b100,
    ST_RETAIN  = 3'b101,
    ST_RECOVER = 3'b110
  } asc_state_t;

  // Memory pins driven by the controller.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              primary_select_n;
    logic              secondary_select;
    logic              output_enable_n;
    logic              write_strobe_n;
    logic              low_lane_enable_n;
    logic              high_lane_enable_n;
  } asc_pins_t;

  localparam asc_pins_t PINS_IDLE = '{addr: '0, primary_select_n: 1'b1,
    secondary_select: 1'b1, output_enable_n: 1'b1, write_strobe_n: 1'b1,
    low_lane_enable_n: 1'b1, high_lane_enable_n: 1'b1};

endpackage : asc_pkg

// ==== rtl/asc_host.sv ====
// Purpose: Host controller driving an async 1M x 16 static memory through its pins.
// Assumes: One request at a time; memory data inputs reach clk_sys_i unsynchronised timing-wise.
// Notes:   Output enable stays high through writes so no bus contention can arise.
`timescale 1ns/1ps
`default_nettype none

module asc_host
  import asc_pkg::*;
(
  // Clock and reset.
  input  wire logic              clk_sys_i,
  input  wire logic              arst_n_i,
  // User request port.
  input  wire logic              req_valid_i,
  input  wire logic              req_write_i,
  input  wire logic [ADDR_W-1:0] req_addr_i,
  input  wire logic [DATA_W-1:0] req_wdata_i,
  input  wire logic [1:0]        req_lanes_i,
  output logic                   req_ready_o,
  output logic                   rsp_valid_o,
  output logic [DATA_W-1:0]      rsp_rdata_o,
  // Retention control.
  input  wire logic              retain_i,
  output logic                   retained_o,
  // Memory pins.
  output asc_pins_t              mem_pins_o,
  input  wire logic [DATA_W-1:0] mem_data_i,
  output logic [DATA_W-1:0]      mem_data_o,
  output logic                   mem_data_oe_o
);

  ////////////////////////////////////////////////////////////////////////////
  asc_state_t        state_ff;
  logic [CNT_W-1:0]  cnt_ff;
  asc_pins_t         pins_ff;
  logic [DATA_W-1:0] wdata_ff;
  logic              oe_ff;
  logic [1:0]        lanes_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic              rsp_ff;
  logic [CNT_W-1:0]  low_cnt_ff;

  assign req_ready_o   = (state_ff == ST_IDLE) && !retain_i;
  assign mem_pins_o    = pins_ff;
  assign mem_data_o    = wdata_ff;
  assign mem_data_oe_o = oe_ff;
  assign rsp_valid_o   = rsp_ff;
  assign rsp_rdata_o   = rdata_ff;
  assign retained_o    = (state_ff == ST_RETAIN);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer. Each phase lasts a whole number of cycles, so every window
  // below is a multiple of 100 ns and comfortably above the memory minima.
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_ff <= ST_IDLE;
      cnt_ff   <= '0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          cnt_ff <= '0;
          if (retain_i) begin
            state_ff <= ST_RETAIN;
          end else if (req_valid_i && req_lanes_i != 2'b00) begin
            state_ff <= req_write_i ? ST_WSETUP : ST_READ;
          end
        end
        ST_READ: begin
          if (cnt_ff == CNT_W'(READ_CYC)) begin
            state_ff <= ST_RECOVER;
            cnt_ff   <= '0;
          end else begin
            cnt_ff <= cnt_ff + 1'b1;
          end
        end
        ST_WSETUP: begin
          state_ff <= ST_WPULSE;
        end
        ST_WPULSE: begin
          if (cnt_ff == CNT_W'(WPULSE_CYC - 1)) begin
            state_ff <= ST_WHOLD;
            cnt_ff   <= '0;
          end else begin
            cnt_ff <= cnt_ff + 1'b1;
          end
        end
        ST_WHOLD: begin
          state_ff <= ST_RECOVER;
        end
        ST_RETAIN: begin
          if (!retain_i) begin
            state_ff <= ST_RECOVER;
            cnt_ff   <= '0;
          end
        end
        ST_RECOVER: begin
          // Gap before the next access covers float time and one read period.
          if (cnt_ff == CNT_W'(RECOVER_CYC - 1)) begin
            state_ff <= ST_IDLE;
            cnt_ff   <= '0;
          end else begin
            cnt_ff <= cnt_ff + 1'b1;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
          cnt_ff   <= '0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory pin drive.
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pins_ff  <= PINS_IDLE;
      lanes_ff <= 2'b00;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          pins_ff <= PINS_IDLE;
          if (req_valid_i && !retain_i && req_lanes_i != 2'b00) begin
            // Address and selects change together; address set up no later.
            pins_ff.addr               <= req_addr_i;
            pins_ff.primary_select_n   <= 1'b0;
            pins_ff.low_lane_enable_n  <= ~req_lanes_i[0];
            pins_ff.high_lane_enable_n <= ~req_lanes_i[1];
            pins_ff.output_enable_n    <= req_write_i;
            lanes_ff                   <= req_lanes_i;
          end else if (retain_i) begin
            pins_ff.secondary_select <= 1'b1;
          end
        end
        ST_WSETUP: begin
          pins_ff.write_strobe_n <= 1'b0;
        end
        ST_WPULSE: begin
          if (cnt_ff == CNT_W'(WPULSE_CYC - 1)) begin
            pins_ff.write_strobe_n <= 1'b1;
          end
        end
        ST_READ: begin
          pins_ff.write_strobe_n <= 1'b1;
          if (cnt_ff == CNT_W'(READ_CYC)) begin
            pins_ff <= PINS_IDLE;
          end
        end
        ST_WHOLD: begin
          pins_ff <= PINS_IDLE;
        end
        default: begin
          pins_ff <= PINS_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data bus drive: only between strobe setup and hold, with output enable high.
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      oe_ff    <= 1'b0;
      wdata_ff <= '0;
    end else begin
      if (state_ff == ST_IDLE && req_valid_i && req_write_i && !retain_i
          && req_lanes_i != 2'b00) begin
        wdata_ff <= req_wdata_i;
      end
      // Drive starts with strobe low and ends one cycle after it rises.
      if (state_ff == ST_WSETUP) begin
        oe_ff <= 1'b1;
      end else if (state_ff == ST_WHOLD) begin
        oe_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read capture once the access time has passed, only enabled lanes.
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_ff <= '0;
      rsp_ff   <= 1'b0;
    end else begin
      rsp_ff <= 1'b0;
      if (state_ff == ST_READ && cnt_ff == CNT_W'(READ_CYC)) begin
        rdata_ff[7:0]  <= lanes_ff[0] ? mem_data_i[7:0] : 8'h00;
        rdata_ff[15:8] <= lanes_ff[1] ? mem_data_i[15:8] : 8'h00;
        rsp_ff         <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counts cycles with the strobe low, so the pulse width is checked without a long repetition.
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      low_cnt_ff <= '0;
    end else if (pins_ff.write_strobe_n) begin
      low_cnt_ff <= '0;
    end else begin
      low_cnt_ff <= low_cnt_ff + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_no_drive_oe_low;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      oe_ff |-> pins_ff.output_enable_n;
  endproperty
  a_no_drive_oe_low: assert property (p_no_drive_oe_low)
    else $error("bus driven with oe low");

  property p_strobe_width;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      $rose(pins_ff.write_strobe_n) |-> low_cnt_ff >= CNT_W'(WPULSE_CYC);
  endproperty
  a_strobe_width: assert property (p_strobe_width)
    else $error("strobe pulse too short");

  property p_read_strobe_high;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      state_ff == ST_READ |-> pins_ff.write_strobe_n;
  endproperty
  a_read_strobe_high: assert property (p_read_strobe_high)
    else $error("strobe low in read");

  property p_write_all_active;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      !pins_ff.write_strobe_n |-> !pins_ff.primary_select_n && pins_ff.secondary_select
        && !(pins_ff.low_lane_enable_n && pins_ff.high_lane_enable_n);
  endproperty
  a_write_all_active: assert property (p_write_all_active)
    else $error("write without selects");

  property p_data_hold;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      $rose(pins_ff.write_strobe_n) |-> oe_ff && $stable(wdata_ff);
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("data not held at write end");

  property p_oe_high_write;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      !pins_ff.write_strobe_n |-> pins_ff.output_enable_n;
  endproperty
  a_oe_high_write: assert property (p_oe_high_write)
    else $error("oe low during write");

  property p_addr_stable;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      !pins_ff.write_strobe_n |-> $stable(pins_ff.addr);
  endproperty
  a_addr_stable: assert property (p_addr_stable)
    else $error("address moved in write");

  property p_retain_pins;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      retained_o |-> pins_ff.primary_select_n && pins_ff.secondary_select
        && pins_ff.low_lane_enable_n && pins_ff.high_lane_enable_n;
  endproperty
  a_retain_pins: assert property (p_retain_pins)
    else $error("retention pins wrong");

  property p_read_resp;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      (state_ff == ST_IDLE && req_valid_i && !req_write_i && !retain_i
       && req_lanes_i != 2'b00) |-> ##[1:3] rsp_valid_o;
  endproperty
  a_read_resp: assert property (p_read_resp)
    else $error("read answer late");

  // The selects lead the strobe by a whole cycle, which covers the select setup.
  property p_sel_before_strobe;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      $fell(pins_ff.write_strobe_n) |-> $past(!pins_ff.primary_select_n && pins_ff.secondary_select);
  endproperty
  a_sel_before_strobe: assert property (p_sel_before_strobe)
    else $error("selects late before write");

  property p_lanes_held;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      !pins_ff.write_strobe_n |-> $stable({pins_ff.low_lane_enable_n, pins_ff.high_lane_enable_n});
  endproperty
  a_lanes_held: assert property (p_lanes_held)
    else $error("lane enables moved in write");

  property p_addr_from_req;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      $fell(pins_ff.primary_select_n) |-> pins_ff.addr == $past(req_addr_i);
  endproperty
  a_addr_from_req: assert property (p_addr_from_req)
    else $error("address not valid at select");

  property p_recover_gap;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      $rose(pins_ff.primary_select_n) |=> pins_ff.primary_select_n;
  endproperty
  a_recover_gap: assert property (p_recover_gap)
    else $error("no gap between accesses");

  property p_idle_deselect;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      state_ff == ST_IDLE |-> pins_ff.primary_select_n && pins_ff.write_strobe_n;
  endproperty
  a_idle_deselect: assert property (p_idle_deselect)
    else $error("memory selected while idle");

  // Main scenarios: reads and writes of any width, retention, and accesses to one byte only.
  c_read: cover property (@(posedge clk_sys_i) rsp_valid_o);
  c_write: cover property (@(posedge clk_sys_i) $rose(pins_ff.write_strobe_n));
  c_retain: cover property (@(posedge clk_sys_i) $fell(retained_o));
  c_byte_write: cover property (@(posedge clk_sys_i) $rose(pins_ff.write_strobe_n)
    && pins_ff.low_lane_enable_n != pins_ff.high_lane_enable_n);
  c_byte_read: cover property (@(posedge clk_sys_i) rsp_valid_o && lanes_ff != 2'b11);

endmodule : asc_host

`default_nettype wire

// ==== tb/asc_sram_model.sv ====
// Purpose: Behavioural model of the async 1M x 16 static memory behind the host controller.
// Assumes: Host pins arrive as asc_pins_t; the bus is resolved here from both drivers.
// Notes:   A floating bus shows the inverse of the memory's last output word, never the host's write data.
`timescale 1ns/1ps
`default_nettype none
module asc_sram_model
  import asc_pkg::*;
(
  // Host side.
  input  wire asc_pins_t         pins_i,
  input  wire logic [DATA_W-1:0] host_data_i,
  input  wire logic              host_oe_i,
  // Resolved bus and fault count.
  output logic [DATA_W-1:0]      bus_o,
  output logic [7:0]             faults_o
);
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [DATA_W-1:0] dq = '0;
  logic [DATA_W-1:0] w;
  logic [ADDR_W-1:0] wa;
  logic [1:0]        ln;
  logic              drv = 1'b0;
  logic              wact;
  logic              in_wr = 1'b0;
  logic              we_n;
  realtime           t_data = 0;
  realtime           t_we = 0;

  initial faults_o = '0;
  assign we_n = pins_i.write_strobe_n;
  assign wact = !pins_i.primary_select_n && pins_i.secondary_select && !we_n &&
                !(pins_i.low_lane_enable_n && pins_i.high_lane_enable_n);

  function automatic logic [DATA_W-1:0] rd_word(input asc_pins_t p);
    logic [DATA_W-1:0] v;
    v = mem.exists(p.addr) ? mem[p.addr] : '0;
    if (p.low_lane_enable_n) v[7:0] = ~v[7:0];
    if (p.high_lane_enable_n) v[15:8] = ~v[15:8];
    return v;
  endfunction : rd_word

  ////////////////////////////////////////////////////////////////////////////////
  always @(pins_i) begin
    if (!pins_i.primary_select_n && pins_i.secondary_select && !pins_i.output_enable_n &&
        we_n && !(pins_i.low_lane_enable_n && pins_i.high_lane_enable_n)) begin
      drv <= #10 1'b1;
      dq  <= #(ADDRESS_ACCESS_DELAY_NS) rd_word(pins_i);
    end else begin
      drv <= #18 1'b0;
    end
  end

  assign bus_o = host_oe_i ? host_data_i : (drv ? dq : ~dq);

  ////////////////////////////////////////////////////////////////////////////////
  always @(host_data_i or host_oe_i) t_data = $realtime;
  always @(negedge we_n) t_we = $realtime;
  always @(host_oe_i or drv) if (host_oe_i && drv) faults_o = faults_o + 8'h01;
  always @(posedge wact) begin
    in_wr = 1'b1;
    wa = pins_i.addr;
    ln = {~pins_i.high_lane_enable_n, ~pins_i.low_lane_enable_n};
  end
  // Only a write that really began may end; the unknown pins before reset must not store.
  always @(negedge wact) begin
    if (in_wr) begin
      if ($realtime - t_data < DATA_SETUP_TO_END_NS) faults_o = faults_o + 8'h01;
      if ($realtime - t_we < WRITE_PULSE_MIN_NS) faults_o = faults_o + 8'h01;
      w = mem.exists(wa) ? mem[wa] : '0;
      if (ln[0]) w[7:0] = host_data_i[7:0];
      if (ln[1]) w[15:8] = host_data_i[15:8];
      mem[wa] = w;
    end
    in_wr = 1'b0;
  end
endmodule : asc_sram_model
`default_nettype wire

// ==== tb/asc_host_tb.sv ====
// Purpose: Self-checking bench for the static memory host controller.
// Assumes: 10 MHz clock; inputs driven 5 ns after the rising edge.
// Notes:   Ordinary accesses run from a table; reset, refusal and retention follow.
`timescale 1ns/1ps
`default_nettype none
module asc_host_tb;
  import asc_pkg::*;
  typedef struct packed {
    logic wr; logic [ADDR_W-1:0] a; logic [DATA_W-1:0] d; logic [1:0] ln; logic [DATA_W-1:0] e;
  } asc_row_t;
  logic              clk_sys_i = 1'b0;
  logic              arst_n_i = 1'b0;
  logic              req_valid_i = 1'b0;
  logic              req_write_i = 1'b0;
  logic [ADDR_W-1:0] req_addr_i = '0;
  logic [DATA_W-1:0] req_wdata_i = '0;
  logic [1:0]        req_lanes_i = '0;
  logic              retain_i = 1'b0;
  logic              req_ready_o, rsp_valid_o, retained_o, mem_data_oe_o;
  logic [DATA_W-1:0] rsp_rdata_o, mem_data_o, bus;
  logic [7:0]        faults;
  asc_pins_t         mem_pins_o;
  int                mismatches = 0;
  int                checks_done = 0;
  int                cyc = 0;
  asc_row_t          rows [9] = '{
    '{1'b1, 20'h00001, 16'h1234, 2'b11, 16'h0000}, '{1'b0, 20'h00001, 16'h0000, 2'b11, 16'h1234},
    '{1'b1, 20'h00001, 16'habcd, 2'b01, 16'h0000}, '{1'b0, 20'h00001, 16'h0000, 2'b11, 16'h12cd},
    '{1'b0, 20'h00001, 16'h0000, 2'b10, 16'h1200}, '{1'b1, 20'h00001, 16'h55aa, 2'b10, 16'h0000},
    '{1'b0, 20'h00001, 16'h0000, 2'b01, 16'h00cd}, '{1'b1, 20'hfffff, 16'hc3a5, 2'b11, 16'h0000},
    '{1'b0, 20'hfffff, 16'h0000, 2'b11, 16'hc3a5}};

  always #50 clk_sys_i = ~clk_sys_i;

  asc_host asc_host_inst (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .req_valid_i(req_valid_i),
    .req_write_i(req_write_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
    .req_lanes_i(req_lanes_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
    .rsp_rdata_o(rsp_rdata_o), .retain_i(retain_i), .retained_o(retained_o),
    .mem_pins_o(mem_pins_o), .mem_data_i(bus), .mem_data_o(mem_data_o),
    .mem_data_oe_o(mem_data_oe_o));
  asc_sram_model asc_sram_model_inst (.pins_i(mem_pins_o), .host_data_i(mem_data_o),
    .host_oe_i(mem_data_oe_o), .bus_o(bus), .faults_o(faults));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [47:0] seen, input logic [47:0] exp, input string msg);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test

  // Picks the flag that wait_for polls, so the live value is read on every pass.
  function automatic logic flag_of(input int sel);
    case (sel)
      0:       return req_ready_o;
      1:       return rsp_valid_o;
      2:       return ~mem_pins_o.write_strobe_n;
      default: return retained_o;
    endcase
  endfunction : flag_of

  // Waits up to n edges for a flag, sampling just after each edge.
  task automatic wait_for(input int sel, input int n, input string msg);
    int i;
    for (i = 0; i < n && flag_of(sel) !== 1'b1; i++) @(posedge clk_sys_i) #1;
    check(flag_of(sel), 1'b1, msg);
  endtask : wait_for

  task automatic do_req(input asc_row_t r);
    wait_for(0, 10, "ready");
    @(posedge clk_sys_i) #5;
    {req_valid_i, req_write_i, req_addr_i, req_wdata_i, req_lanes_i} = {1'b1, r.wr, r.a, r.d, r.ln};
    @(posedge clk_sys_i) #5;
    req_valid_i = 1'b0;
    if (r.wr) begin
      wait_for(2, 6, "strobe");
      check(mem_pins_o.output_enable_n, 1'b1, "oe in write");
      check({mem_data_oe_o, mem_data_o}, {1'b1, r.d}, "write data");
      check({mem_pins_o.addr, mem_pins_o.high_lane_enable_n, mem_pins_o.low_lane_enable_n},
        {r.a, ~r.ln}, "write addr");
    end else begin
      check({mem_pins_o.primary_select_n, mem_pins_o.output_enable_n,
        mem_pins_o.write_strobe_n}, 3'b001, "read pins");
      wait_for(1, 6, "rsp");
      check(rsp_rdata_o, r.e, "rdata");
      @(posedge clk_sys_i) #1;
      check(rsp_valid_o, 1'b0, "rsp pulse");
    end
  endtask : do_req

  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk_sys_i);
    #5;
    check({mem_pins_o, mem_data_oe_o, rsp_valid_o}, {PINS_IDLE, 2'b00}, "reset pins");
    arst_n_i = 1'b1;
    $display("reset test done");
    foreach (rows[i]) do_req(rows[i]);
    $display("table test done");
    wait_for(0, 10, "ready");
    @(posedge clk_sys_i) #5;
    {req_valid_i, req_lanes_i} = {1'b1, 2'b00};
    @(posedge clk_sys_i) #5;
    req_valid_i = 1'b0;
    check({req_ready_o, mem_pins_o.primary_select_n}, 2'b11, "no lanes");
    $display("empty lanes test done");
    retain_i = 1'b1;
    wait_for(3, 10, "retain");
    check({mem_pins_o.primary_select_n, mem_pins_o.secondary_select,
      mem_pins_o.low_lane_enable_n, mem_pins_o.high_lane_enable_n}, 4'hf, "retain pins");
    check(req_ready_o, 1'b0, "ready in retain");
    repeat (2) @(posedge clk_sys_i);
    #5 retain_i = 1'b0;
    do_req('{1'b0, 20'h00001, 16'h0000, 2'b11, 16'h55cd});
    $display("retention test done");
    // Reset in the middle of a read must drop the pins at once and keep the memory.
    wait_for(0, 10, "ready");
    @(posedge clk_sys_i) #5;
    {req_valid_i, req_write_i, req_addr_i, req_lanes_i} = {1'b1, 1'b0, 20'hfffff, 2'b11};
    @(posedge clk_sys_i) #5;
    check(mem_pins_o.primary_select_n, 1'b0, "select in read");
    {req_valid_i, arst_n_i} = 2'b00;
    #1 check({mem_pins_o, mem_data_oe_o, rsp_valid_o}, {PINS_IDLE, 2'b00}, "mid reset");
    @(posedge clk_sys_i) #5;
    arst_n_i = 1'b1;
    check(req_ready_o, 1'b1, "ready after reset");
    do_req('{1'b0, 20'hfffff, 16'h0000, 2'b11, 16'hc3a5});
    $display("mid reset test done");
    check(faults, 8'h00, "bus timing faults");
    stop_test();
  end
endmodule : asc_host_tb
`default_nettype wire
